// File: nvpg_pkg.sv
// Shared constants for the nonvolatile paging and timing clock block
package nvpg_pkg;

	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;

	// APB byte offsets
	localparam logic [ADDR_W-1:0] OFF_RATIO = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_CONFIG = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_OPTIONS = 12'h008;
	localparam logic [ADDR_W-1:0] OFF_COMMAND = 12'h00C;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h010;
	localparam logic [ADDR_W-1:0] OFF_WINDOW = 12'h400;

	// Field positions
	localparam int unsigned RATIO_LOADED_BIT = 7;
	localparam int unsigned RATIO_PRESCALE_BIT = 6;
	localparam int unsigned RATIO_DIV_W = 6;
	localparam int unsigned CONFIG_PAGE_BIT = 6;
	localparam int unsigned OPTIONS_MODE_BIT = 5;
	localparam int unsigned COMMAND_ERASE_BIT = 0;
	localparam int unsigned STATUS_BUSY_BIT = 0;
	localparam int unsigned STATUS_REFUSED_BIT = 1;
	localparam int unsigned BYTE_W = 8;

	// Reset values
	localparam logic [7:0] RATIO_RESET = 8'h00;
	localparam logic CONFIG_PAGE_RESET = 1'b0;
	localparam logic OPTIONS_MODE_RESET = 1'b0;

	// Array geometry
	localparam int unsigned SECTOR_LSB = 3;
	localparam logic [2:0] SECTOR_LAST = 3'h7;
	localparam int unsigned HALF_LSB = 2;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [1:0] WORD_ALIGNED = 2'h0;

	// Prescaler divides the bus clock by eight
	localparam int unsigned PRESCALE_DIV = 8;
	localparam logic [2:0] PRESCALE_LAST = 3'(PRESCALE_DIV - 1);

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RUN = 3'b010,
		ST_COMMIT = 3'b100
	} nvpg_state_type;

endpackage

// File: nvpg_clkdiv.sv
// Timing clock divider: prescaler and ratio counter producing one tick a period
`timescale 1ns/1ps
`default_nettype none
module nvpg_clkdiv #(
	parameter int unsigned DIV_W = 6
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic run_i,
	input wire logic prescale_i,
	input wire logic [DIV_W-1:0] ratio_i,
	output logic tick_o
);

	if (DIV_W < 1 || DIV_W > 8) begin : gen_bad_width
		$error("nvpg_clkdiv: DIV_W must be 1 to 8");
	end

	logic [2:0] pre_q;
	logic [DIV_W-1:0] div_q;
	logic tick_q;
	logic pre_tick;
	logic div_wrap;

	// Counters restart whenever run drops, so every tick closes a full period
	assign pre_tick = !prescale_i || pre_q == nvpg_pkg::PRESCALE_LAST;
	assign div_wrap = pre_tick && div_q == ratio_i;

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i || !run_i) begin
			pre_q <= '0;
		end else begin
			pre_q <= pre_q + 3'h1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i || !run_i) begin
			div_q <= '0;
		end else if (div_wrap) begin
			div_q <= '0;
		end else if (pre_tick) begin
			div_q <= div_q + DIV_W'(1);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= run_i && div_wrap;
		end
	end

	assign tick_o = tick_q;

	// Cycles since run start or the last tick
	logic [10:0] gap_q;
	logic [10:0] period;
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i || !run_i) begin
			gap_q <= '0;
		end else if (tick_q) begin
			gap_q <= 11'h001;
		end else begin
			gap_q <= gap_q + 11'h001;
		end
	end
	assign period = (11'(ratio_i) + 11'h001)
		* (prescale_i ? 11'(nvpg_pkg::PRESCALE_DIV) : 11'h001);

	tick_period_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		tick_q |-> gap_q == period)
		else $error("timing tick period differs from ratio setting");

endmodule
`default_nettype wire

// File: nvpg_top.sv
// EEPROM paging, write-once timing clock ratio and program/erase sequencer
`timescale 1ns/1ps
`default_nettype none
module nvpg_top #(
	parameter int unsigned EE_BYTES = 256,
	parameter int unsigned PROG_PULSES = 9,
	parameter int unsigned ERASE_PULSES = 40
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [nvpg_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [nvpg_pkg::DATA_W-1:0] pwdata_i,
	output logic [nvpg_pkg::DATA_W-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic ratio_loaded_o,
	output logic nvm_busy_o,
	output logic timing_tick_o
);

	localparam int unsigned VIS_W = $clog2(EE_BYTES / 2);
	localparam int unsigned PH_W = VIS_W + 1;
	localparam int unsigned CNT_W = 16;
	localparam int unsigned DIV_W = nvpg_pkg::RATIO_DIV_W;

	if (EE_BYTES < 16 || EE_BYTES > 512 || (1 << $clog2(EE_BYTES)) != EE_BYTES)
	begin : gen_bad_size
		$error("nvpg_top: EE_BYTES must be a power of two, 16 to 512");
	end
	if (PROG_PULSES < 1 || ERASE_PULSES < 1 || PROG_PULSES >= (1 << CNT_W)
		|| ERASE_PULSES >= (1 << CNT_W)) begin : gen_bad_pulses
		$error("nvpg_top: pulse counts must be 1 to 65535");
	end

	// Register state
	logic loaded_q;
	logic prescale_q;
	logic [DIV_W-1:0] div_q;
	logic page_q;
	logic mode_q;
	logic erase_arm_q;
	logic refused_q;
	logic busy_q;
	nvpg_pkg::nvpg_state_type state_q;
	logic op_erase_q;
	logic [PH_W-1:0] op_idx_q;
	logic [7:0] op_data_q;
	logic [CNT_W-1:0] left_q;
	logic [nvpg_pkg::DATA_W-1:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic tick;
	logic [7:0] mem_w [EE_BYTES];

	// Bus decode
	logic hit_ratio;
	logic hit_config;
	logic hit_options;
	logic hit_command;
	logic hit_status;
	logic win_hit;
	logic [VIS_W-1:0] vis_idx;
	logic [PH_W-1:0] phys_idx;
	logic access_first;
	logic access_done;
	logic wr;
	logic win_wr;
	logic start;
	logic commit;

	assign hit_ratio = paddr_i == nvpg_pkg::OFF_RATIO;
	assign hit_config = paddr_i == nvpg_pkg::OFF_CONFIG;
	assign hit_options = paddr_i == nvpg_pkg::OFF_OPTIONS;
	assign hit_command = paddr_i == nvpg_pkg::OFF_COMMAND;
	assign hit_status = paddr_i == nvpg_pkg::OFF_STATUS;
	assign win_hit = (paddr_i >> (VIS_W + 2)) ==
		(nvpg_pkg::OFF_WINDOW >> (VIS_W + 2))
		&& paddr_i[1:0] == nvpg_pkg::WORD_ALIGNED;
	assign vis_idx = paddr_i[VIS_W+1:2];

	// Visible address to array byte; hidden bytes have no address at all
	function automatic logic [PH_W-1:0] phys_of(
		input logic [VIS_W-1:0] a,
		input logic pg,
		input logic md
	);
		if (md) begin
			phys_of = {pg, a};
		end else begin
			phys_of = {a[VIS_W-1:nvpg_pkg::HALF_LSB], pg,
				a[nvpg_pkg::HALF_LSB-1:0]};
		end
	endfunction

	assign phys_idx = phys_of(vis_idx, page_q, mode_q);

	// One wait state so read data leaves straight from a flop
	assign access_first = psel_i && penable_i && !pready_q;
	assign access_done = psel_i && penable_i && pready_q;
	assign wr = access_done && pwrite_i;
	assign win_wr = wr && win_hit;
	assign start = win_wr && loaded_q && state_q == nvpg_pkg::ST_IDLE;
	assign commit = state_q == nvpg_pkg::ST_COMMIT;

	logic [nvpg_pkg::DATA_W-1:0] rd_d;
	logic err_d;
	always_comb begin
		rd_d = '0;
		err_d = 1'b0;
		if (hit_ratio) begin
			rd_d[nvpg_pkg::RATIO_LOADED_BIT] = loaded_q;
			rd_d[nvpg_pkg::RATIO_PRESCALE_BIT] = prescale_q;
			rd_d[DIV_W-1:0] = div_q;
		end else if (hit_config) begin
			rd_d[nvpg_pkg::CONFIG_PAGE_BIT] = page_q;
		end else if (hit_options) begin
			rd_d[nvpg_pkg::OPTIONS_MODE_BIT] = mode_q;
		end else if (hit_command) begin
			rd_d[nvpg_pkg::COMMAND_ERASE_BIT] = erase_arm_q;
		end else if (hit_status) begin
			rd_d[nvpg_pkg::STATUS_BUSY_BIT] = busy_q;
			rd_d[nvpg_pkg::STATUS_REFUSED_BIT] = refused_q;
		end else if (win_hit) begin
			rd_d[nvpg_pkg::BYTE_W-1:0] = mem_w[phys_idx];
		end else begin
			err_d = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= '0;
		end else begin
			pready_q <= access_first;
			pslverr_q <= access_first && err_d;
			if (access_first) begin
				prdata_q <= pwrite_i ? '0 : rd_d;
			end
		end
	end

	// Write-once ratio register; the loaded flag itself is never written
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			loaded_q <= nvpg_pkg::RATIO_RESET[nvpg_pkg::RATIO_LOADED_BIT];
			prescale_q <= nvpg_pkg::RATIO_RESET[nvpg_pkg::RATIO_PRESCALE_BIT];
			div_q <= nvpg_pkg::RATIO_RESET[DIV_W-1:0];
		end else if (wr && hit_ratio && !loaded_q) begin
			loaded_q <= 1'b1;
			prescale_q <= pwdata_i[nvpg_pkg::RATIO_PRESCALE_BIT];
			div_q <= pwdata_i[DIV_W-1:0];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			page_q <= nvpg_pkg::CONFIG_PAGE_RESET;
			mode_q <= nvpg_pkg::OPTIONS_MODE_RESET;
			erase_arm_q <= 1'b0;
		end else if (wr) begin
			if (hit_config) begin
				page_q <= pwdata_i[nvpg_pkg::CONFIG_PAGE_BIT];
			end
			if (hit_options) begin
				mode_q <= pwdata_i[nvpg_pkg::OPTIONS_MODE_BIT];
			end
			if (hit_command) begin
				erase_arm_q <= pwdata_i[nvpg_pkg::COMMAND_ERASE_BIT];
			end
		end
	end

	// A new refusal in the clearing cycle keeps the flag set
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			refused_q <= 1'b0;
		end else if (win_wr && !start) begin
			refused_q <= 1'b1;
		end else if (wr && hit_status
			&& pwdata_i[nvpg_pkg::STATUS_REFUSED_BIT]) begin
			refused_q <= 1'b0;
		end
	end

	// Sequencer counts whole timing pulses, then commits to the array
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			state_q <= nvpg_pkg::ST_IDLE;
			busy_q <= 1'b0;
			op_erase_q <= 1'b0;
			op_idx_q <= '0;
			op_data_q <= '0;
			left_q <= '0;
		end else begin
			unique case (state_q)
				nvpg_pkg::ST_IDLE: begin
					if (start) begin
						state_q <= nvpg_pkg::ST_RUN;
						busy_q <= 1'b1;
						op_erase_q <= erase_arm_q;
						op_idx_q <= phys_idx;
						op_data_q <= pwdata_i[nvpg_pkg::BYTE_W-1:0];
						left_q <= erase_arm_q ? CNT_W'(ERASE_PULSES - 1)
							: CNT_W'(PROG_PULSES - 1);
					end
				end
				nvpg_pkg::ST_RUN: begin
					if (tick) begin
						if (left_q == '0) begin
							state_q <= nvpg_pkg::ST_COMMIT;
						end else begin
							left_q <= left_q - CNT_W'(1);
						end
					end
				end
				nvpg_pkg::ST_COMMIT: begin
					state_q <= nvpg_pkg::ST_IDLE;
					busy_q <= 1'b0;
				end
			endcase
		end
	end

	// Divider only runs during an operation so the first pulse is full length
	nvpg_clkdiv #(
		.DIV_W(DIV_W)
	) u_clkdiv (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.run_i(state_q == nvpg_pkg::ST_RUN),
		.prescale_i(prescale_q),
		.ratio_i(div_q),
		.tick_o(tick)
	);

	// Array cells hold their contents through reset, as a real array would
	for (genvar gi = 0; gi < EE_BYTES; gi++) begin : gen_cell
		localparam logic [PH_W-1:0] IDX = PH_W'(gi);
		logic [7:0] cell_q;
		always_ff @(posedge ref_clk_i) begin
			if (commit) begin
				if (op_erase_q) begin
					if (op_idx_q[PH_W-1:nvpg_pkg::SECTOR_LSB]
						== IDX[PH_W-1:nvpg_pkg::SECTOR_LSB]) begin
						cell_q <= nvpg_pkg::ERASED_BYTE;
					end
				end else if (op_idx_q == IDX) begin
					cell_q <= cell_q & op_data_q;
				end
			end
		end
		assign mem_w[gi] = cell_q;
	end

	assign prdata_o = prdata_q;
	assign pready_o = pready_q;
	assign pslverr_o = pslverr_q;
	assign ratio_loaded_o = loaded_q;
	assign nvm_busy_o = busy_q;
	assign timing_tick_o = tick;

	// Pulses seen during the current operation
	logic [CNT_W-1:0] seen_q;
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i || start) begin
			seen_q <= '0;
		end else if (state_q == nvpg_pkg::ST_RUN && tick) begin
			seen_q <= seen_q + CNT_W'(1);
		end
	end

	pulse_count_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		state_q == nvpg_pkg::ST_COMMIT |-> seen_q == (op_erase_q
		? CNT_W'(ERASE_PULSES) : CNT_W'(PROG_PULSES)))
		else $error("operation did not use the set number of pulses");

	ratio_once_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		loaded_q |=> loaded_q && $stable(prescale_q) && $stable(div_q))
		else $error("ratio setting changed after first write");

	loaded_set_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		wr && hit_ratio |=> loaded_q ##1 prdata_q[nvpg_pkg::RATIO_LOADED_BIT]
		|| !pready_q)
		else $error("first ratio write did not set loaded flag");

	refuse_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		win_wr && !loaded_q |=> state_q == nvpg_pkg::ST_IDLE && refused_q)
		else $error("operation accepted before ratio was loaded");

	erase_block_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		commit && op_erase_q |=> mem_w[{op_idx_q[PH_W-1:nvpg_pkg::SECTOR_LSB],
		3'h0}] == nvpg_pkg::ERASED_BYTE && mem_w[{op_idx_q[PH_W-1:
		nvpg_pkg::SECTOR_LSB], nvpg_pkg::SECTOR_LAST}] == nvpg_pkg::ERASED_BYTE)
		else $error("sector erase left bytes of the sector");

	program_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		commit && !op_erase_q |=> mem_w[op_idx_q] ==
		($past(mem_w[op_idx_q]) & op_data_q))
		else $error("byte program wrote wrong value");

	page_map_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		mode_q ? phys_idx[PH_W-1] == page_q
		: phys_idx[nvpg_pkg::HALF_LSB] == page_q)
		else $error("visible address maps into hidden page");

	ready_pulse_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		pready_q |=> !pready_q)
		else $error("pready held longer than one cycle");

endmodule
`default_nettype wire

// File: nvpg_top_tb.sv
// Self-checking bench for the paging and timing clock block
`timescale 1ns/1ps
`default_nettype none
module nvpg_top_tb;
	localparam int unsigned EE = 32;
	localparam int unsigned PP = 2;
	localparam int unsigned EP = 3;
	// Prescale on, divisor 12: 20 MHz / 104 keeps the timing clock near 192 kHz
	localparam logic [31:0] RATIO_LEGAL = 32'h0000004C;
	localparam logic [31:0] RATIO_READ = 32'h000000CC;
	localparam int PER = 104;
	localparam logic [11:0] UNMAPPED = 12'h020;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic loaded;
	logic busy;
	logic tick;
	int miscompares = 0;
	int comparisons = 0;
	logic [31:0] rd;
	logic err;
	int ticks;
	int gap;

	nvpg_top #(.EE_BYTES(EE), .PROG_PULSES(PP), .ERASE_PULSES(EP)) dut_u (
		.ref_clk_i(clk),
		.sys_rst_i(rst),
		.psel_i(psel),
		.penable_i(penable),
		.pwrite_i(pwrite),
		.paddr_i(paddr),
		.pwdata_i(pwdata),
		.prdata_o(prdata),
		.pready_o(pready),
		.pslverr_o(pslverr),
		.ratio_loaded_o(loaded),
		.nvm_busy_o(busy),
		.timing_tick_o(tick)
	);

	initial begin
		forever #25 clk = ~clk;
	end

	task end_of_test;
		if (miscompares == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task chk32(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task chk_bit(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask

	// Held until pready is seen high at a rising edge, then released
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			miscompares++;
			end_of_test();
		end
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h00000000);
		chk32(rd, exp);
		chk_bit(err, 1'b0);
	endtask

	function automatic logic [11:0] win(input int a);
		return nvpg_pkg::OFF_WINDOW + 12'(4 * a);
	endfunction

	// Starts one operation and checks pulse count and pulse spacing
	task op(input int a, input logic [31:0] d, input int n, input int per);
		int k;
		wr(win(a), d);
		k = 0;
		while (busy !== 1'b1 && k < 5) begin
			@(posedge clk);
			k++;
		end
		chk_bit(busy, 1'b1);
		ticks = 0;
		gap = 0;
		k = 0;
		while (busy === 1'b1 && k < 5000) begin
			@(posedge clk);
			k++;
			gap++;
			if (tick === 1'b1) begin
				chk32(32'(gap), 32'(per));
				ticks++;
				gap = 0;
			end
		end
		chk32(32'(ticks), 32'(n));
		if (k >= 5000) begin
			miscompares++;
			end_of_test();
		end
	endtask

	task do_reset;
		rst <= 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
	endtask

	initial begin
		do_reset();
		@(posedge clk);
		chk_bit(loaded, 1'b0);
		rdchk(nvpg_pkg::OFF_RATIO, 32'h00000000);
		wr(win(0), 32'h00000000);
		rdchk(nvpg_pkg::OFF_STATUS, 32'h00000002);
		chk_bit(busy, 1'b0);
		wr(nvpg_pkg::OFF_STATUS, 32'h00000002);
		rdchk(nvpg_pkg::OFF_STATUS, 32'h00000000);
		apb(1'b0, UNMAPPED, 32'h00000000);
		chk_bit(err, 1'b1);
		chk32(rd, 32'h00000000);
		wr(nvpg_pkg::OFF_RATIO, RATIO_LEGAL);
		rdchk(nvpg_pkg::OFF_RATIO, RATIO_READ);
		chk_bit(loaded, 1'b1);
		wr(nvpg_pkg::OFF_RATIO, 32'h0000003F);
		rdchk(nvpg_pkg::OFF_RATIO, RATIO_READ);
		// Four-byte mode: erase hits both halves of the sector
		wr(nvpg_pkg::OFF_COMMAND, 32'h00000001);
		op(0, 32'h00000000, EP, PER);
		for (int p = 0; p < 2; p++) begin
			wr(nvpg_pkg::OFF_CONFIG, 32'(p) << 6);
			for (int a = 0; a < 4; a++) rdchk(win(a), 32'h000000FF);
		end
		wr(nvpg_pkg::OFF_COMMAND, 32'h00000000);
		wr(nvpg_pkg::OFF_CONFIG, 32'h00000000);
		op(1, 32'h00000012, PP, PER);
		rdchk(win(1), 32'h00000012);
		wr(nvpg_pkg::OFF_CONFIG, 32'h00000040);
		rdchk(win(1), 32'h000000FF);
		op(1, 32'h00000034, PP, PER);
		rdchk(win(1), 32'h00000034);
		wr(nvpg_pkg::OFF_CONFIG, 32'h00000000);
		rdchk(win(1), 32'h00000012);
		// Eight-byte mode: the old halves now sit side by side in page 0
		wr(nvpg_pkg::OFF_OPTIONS, 32'h00000020);
		rdchk(win(5), 32'h00000034);
		wr(nvpg_pkg::OFF_CONFIG, 32'h00000040);
		wr(nvpg_pkg::OFF_COMMAND, 32'h00000001);
		op(2, 32'h00000000, EP, PER);
		wr(nvpg_pkg::OFF_COMMAND, 32'h00000000);
		op(1, 32'h00000056, PP, PER);
		wr(nvpg_pkg::OFF_CONFIG, 32'h00000000);
		rdchk(win(1), 32'h00000012);
		wr(nvpg_pkg::OFF_COMMAND, 32'h00000001);
		op(6, 32'h00000000, EP, PER);
		rdchk(win(1), 32'h000000FF);
		rdchk(win(5), 32'h000000FF);
		wr(nvpg_pkg::OFF_CONFIG, 32'h00000040);
		rdchk(win(1), 32'h00000056);
		// A window write while busy is refused; reset then lands mid-operation
		wr(win(2), 32'h00000000);
		wr(win(3), 32'h00000000);
		rdchk(nvpg_pkg::OFF_STATUS, 32'h00000003);
		// Second reset: prescaler off checks the divider alone, outside the band
		do_reset();
		@(posedge clk);
		chk_bit(loaded, 1'b0);
		chk_bit(busy, 1'b0);
		rdchk(nvpg_pkg::OFF_STATUS, 32'h00000000);
		wr(nvpg_pkg::OFF_RATIO, 32'h00000002);
		rdchk(nvpg_pkg::OFF_RATIO, 32'h00000082);
		wr(nvpg_pkg::OFF_COMMAND, 32'h00000001);
		op(0, 32'h00000000, EP, 3);
		end_of_test();
	end
endmodule
`default_nettype wire
